// [core/acc_cmp_filt.sv]
`timescale 1ns/1ps
`default_nettype none
// Purpose: comparator sync, de-bounce, invert and trigger
// Assumes: raw comparator output is asynchronous
// Notes:   event is a one-cycle pulse except in level mode
module acc_cmp_filt import acc_pkg::*; (
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_srst,
   // analog comparator
   input  wire logic i_raw,
   // control
   acc_link_if.filt  lk
);
   logic [2:0] sync_reg;
   logic       acc_reg;
   logic       stab_reg;
   logic [3:0] cnt_reg;
   logic       prev_reg;
   logic [3:0] len;
   logic       seen;

   // three-stage sync, change accepted when stages two and three agree
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         sync_reg <= 3'h7;
         acc_reg  <= 1'b1;
      end else begin
         sync_reg <= {sync_reg[1:0], i_raw};
         if (sync_reg[1] == sync_reg[2]) acc_reg <= sync_reg[2];
      end
   end

   // forced high while powered down
   assign seen = acc_reg | lk.cmp_pd;
   assign lk.cmp_raw = seen;

   always_comb begin
      unique case (lk.cmp_dbs)
         2'b01:   len = DB_LEN4;
         2'b10:   len = DB_LEN8;
         2'b11:   len = DB_LEN16;
         default: len = 4'd0;
      endcase
   end

   // new level must persist len+1 clocks
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         stab_reg <= 1'b1;
         cnt_reg  <= 4'd0;
      end else if (seen == stab_reg) begin
         cnt_reg <= 4'd0;
      end else if (cnt_reg >= len) begin
         stab_reg <= seen;
         cnt_reg  <= 4'd0;
      end else begin
         cnt_reg <= cnt_reg + 4'd1;
      end
   end

   // final output and trigger edge memory
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         lk.cmp_final <= 1'b1;
         prev_reg     <= 1'b1;
      end else begin
         lk.cmp_final <= stab_reg ^ lk.cmp_inv;
         prev_reg     <= lk.cmp_final;
      end
   end

   // trigger detection on final output
   always_comb begin
      unique case (acc_trig_t'(lk.cmp_trig))
         TRIG_RISE: lk.cmp_event = lk.cmp_final && !prev_reg;
         TRIG_FALL: lk.cmp_event = !lk.cmp_final && prev_reg;
         TRIG_BOTH: lk.cmp_event = lk.cmp_final != prev_reg;
         TRIG_HIGH: lk.cmp_event = lk.cmp_final;
      endcase
   end

   property p_inv;
      @(posedge i_clk) disable iff (i_srst)
      !$past(i_srst) |-> lk.cmp_final == ($past(stab_reg) ^ $past(lk.cmp_inv));
   endproperty
   a_inv: assert property (p_inv) else $error("final output not invert of filter");

   property p_db8;
      @(posedge i_clk) disable iff (i_srst)
      ($changed(stab_reg) && $past(lk.cmp_dbs) == 2'b10) |-> $past(cnt_reg) == DB_LEN8;
   endproperty
   a_db8: assert property (p_db8) else $error("eight clock de-bounce wrong");
endmodule
`default_nettype wire

// [core/acc_conv_seq.sv]
`timescale 1ns/1ps
`default_nettype none
// Purpose: converter clock divider and conversion timer
// Assumes: divider select steady during a conversion
// Notes:   done is a one-cycle pulse
module acc_conv_seq import acc_pkg::*; (
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_srst,
   // control
   acc_link_if.seq   lk
);
   logic [7:0] pre_reg;
   logic [4:0] cyc_reg;
   logic       busy_reg;
   logic [7:0] mask;
   logic       tick;

   // divisor 2^(8-sel): 256 at 000 down to 2 at 111
   assign mask = 8'hff >> lk.conv_div;
   assign tick = busy_reg && ((pre_reg & mask) == mask);

   // prescaler and divided clock
   always_ff @(posedge i_clk) begin
      if (i_srst || lk.conv_go) begin
         pre_reg     <= 8'h00;
         lk.conv_clk <= 1'b0;
      end else if (busy_reg) begin
         pre_reg     <= pre_reg + 8'h01;
         lk.conv_clk <= ((pre_reg & mask) >= (mask >> 1)) && !tick;
      end
   end

   // fixed count of converter clocks per conversion
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         busy_reg     <= 1'b0;
         cyc_reg      <= 5'd0;
         lk.conv_done <= 1'b0;
      end else begin
         lk.conv_done <= 1'b0;
         if (lk.conv_go) begin
            busy_reg <= 1'b1;
            cyc_reg  <= 5'd0;
         end else if (tick) begin
            if (cyc_reg == CONV_CLOCKS - 5'd1) begin
               busy_reg     <= 1'b0;
               lk.conv_done <= 1'b1;
            end else begin
               cyc_reg <= cyc_reg + 5'd1;
            end
         end
      end
   end

   property p_div2;
      @(posedge i_clk) disable iff (i_srst)
      (tick && lk.conv_div == 3'h7 && !lk.conv_go) ##1 busy_reg |-> !tick ##1 tick;
   endproperty
   a_div2: assert property (p_div2) else $error("divide by two tick spacing wrong");
endmodule
`default_nettype wire

// [core/acc_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
// carries converter and comparator signals inside the block
interface acc_link_if;
   logic        conv_go;
   logic [2:0]  conv_div;
   logic        conv_done;
   logic        conv_clk;
   logic        cmp_pd;
   logic        cmp_inv;
   logic [1:0]  cmp_dbs;
   logic [1:0]  cmp_trig;
   logic        cmp_raw;
   logic        cmp_final;
   logic        cmp_event;
   modport ctl  (output conv_go, conv_div, cmp_pd, cmp_inv, cmp_dbs, cmp_trig,
                 input conv_done, conv_clk, cmp_raw, cmp_final, cmp_event);
   modport seq  (input conv_go, conv_div, output conv_done, conv_clk);
   modport filt (input cmp_pd, cmp_inv, cmp_dbs, cmp_trig,
                 output cmp_raw, cmp_final, cmp_event);
endinterface
`default_nettype wire

// [core/acc_pkg.sv]
// Purpose: constants for converter and comparator control
// Assumes: register index space, byte address = 4 * index
// Notes:   Functional notes below
package acc_pkg;
   // ==========================
   // register indices
   localparam logic [8:0] IDX_IEN0 = 9'h00b;
   localparam logic [8:0] IDX_IFL0 = 9'h00c;
   localparam logic [8:0] IDX_IEN1 = 9'h00d;
   localparam logic [8:0] IDX_IFL1 = 9'h00e;
   localparam logic [8:0] IDX_RESH = 9'h017;
   localparam logic [8:0] IDX_CTL  = 9'h018;
   localparam logic [8:0] IDX_ISEL = 9'h019;
   localparam logic [8:0] IDX_CCTL = 9'h18d;
   localparam logic [8:0] IDX_CSEL = 9'h18e;
   localparam logic [8:0] IDX_DAC  = 9'h18f;
   // ==========================
   // field positions
   localparam int B_CONV_IRQ  = 7;
   localparam int B_CMP_IRQ   = 4;
   localparam int B_START     = 3;
   localparam int B_PD        = 7;
   localparam int B_RAW       = 6;
   localparam int B_OE        = 5;
   localparam int B_INV       = 4;
   localparam int B_NEG_SRC   = 7;
   localparam int B_DAC_REF   = 7;
   // ==========================
   // reset values
   localparam logic [4:0] RST_CHAN  = 5'h1f;
   localparam logic [1:0] RST_REF   = 2'h0;
   localparam logic [7:0] RST_CCTL  = 8'hc0;
   localparam logic [7:0] RST_CSEL  = 8'hff;
   localparam logic [7:0] RST_DAC   = 8'h00;
   // ==========================
   // decode and timing
   localparam logic [4:0] CH_LAST_PIN = 5'h0c;
   localparam logic [4:0] CH_BANDGAP  = 5'h0e;
   localparam logic [4:0] CH_QUARTER  = 5'h17;
   localparam logic [2:0] NEG_RSVD    = 3'h2;
   localparam logic [2:0] POS_RSVD    = 3'h3;
   localparam logic [4:0] CONV_CLOCKS = 5'd14;
   localparam logic [3:0] DB_LEN4     = 4'd3;
   localparam logic [3:0] DB_LEN8     = 4'd7;
   localparam logic [3:0] DB_LEN16    = 4'hf;
   typedef enum logic [1:0] {TRIG_RISE, TRIG_FALL, TRIG_BOTH, TRIG_HIGH} acc_trig_t;
endpackage

// [core/acc_top.sv]
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Purpose: converter and comparator control with Avalon-MM slave
// Assumes: word addresses are register indices, data in low byte
// Notes:   one wait cycle per access; unmapped reads return zero
module acc_top import acc_pkg::*; (
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_srst,
   // avalon-mm slave
   input  wire logic [8:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   output logic [31:0]      o_avs_readdata,
   output logic             o_avs_waitrequest,
   // converter analog side
   input  wire logic [11:0] i_conv_result,
   output logic             o_conv_clk,
   output logic             o_conv_active,
   output logic [4:0]       o_conv_channel_sel,
   output logic             o_conv_channel_valid,
   output logic [1:0]       o_conv_reference_sel,
   // comparator analog side
   input  wire logic        i_comparator_raw_out,
   output logic             o_comparator_power_down,
   output logic             o_negative_source_sel,
   output logic [2:0]       o_negative_pin_sel,
   output logic             o_negative_pin_connect,
   output logic [2:0]       o_positive_pin_sel,
   output logic             o_positive_pin_connect,
   output logic             o_dac_reference_sel,
   output logic [6:0]       o_dac_level_code,
   // comparator pin and interrupt requests
   output logic             o_comparator_pin_out,
   output logic             o_comparator_pin_oe,
   output logic             o_conv_irq,
   output logic             o_comparator_irq
);
   // ==========================
   // state
   acc_link_if lk();
   logic        wait_reg;
   logic        conv_ie_reg;
   logic        conv_pend_reg;
   logic        cmp_ie_reg;
   logic        cmp_pend_reg;
   logic [11:0] result_reg;
   logic        start_reg;
   logic [2:0]  div_reg;
   logic [1:0]  ref_reg;
   logic [4:0]  chan_reg;
   logic [7:0]  cctl_reg;
   logic [7:0]  csel_reg;
   logic [7:0]  dac_reg;
   logic [7:0]  rd_next;
   logic        req;
   logic        wr;
   logic [7:0]  wd;

   // ==========================
   // avalon handshake: answer in the cycle after the request
   assign req = i_avs_read || i_avs_write;
   assign wr  = i_avs_write && !wait_reg && i_avs_byteenable[0];
   assign wd  = i_avs_writedata[7:0];

   always_ff @(posedge i_clk) begin
      if (i_srst) wait_reg <= 1'b1;
      else        wait_reg <= !(req && wait_reg);
   end
   assign o_avs_waitrequest = wait_reg;

   // read mux, reserved and foreign bits read zero
   always_comb begin
      unique case (i_avs_address)
         IDX_IEN0: rd_next = {conv_ie_reg, 7'h00};
         IDX_IFL0: rd_next = {conv_pend_reg, 7'h00};
         IDX_IEN1: rd_next = {3'h0, cmp_ie_reg, 4'h0};
         IDX_IFL1: rd_next = {3'h0, cmp_pend_reg, 4'h0};
         IDX_RESH: rd_next = result_reg[11:4];
         IDX_CTL:  rd_next = {result_reg[3:0], start_reg, div_reg};
         IDX_ISEL: rd_next = {ref_reg, 1'b0, chan_reg};
         IDX_CCTL: rd_next = {cctl_reg[7], lk.cmp_raw, cctl_reg[5:0]};
         IDX_CSEL: rd_next = csel_reg;
         IDX_DAC:  rd_next = dac_reg;
         default:  rd_next = 8'h00;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_srst)                   o_avs_readdata <= 32'h0;
      else if (i_avs_read && wait_reg) o_avs_readdata <= {24'h0, rd_next};
   end

   // ==========================
   // interrupt enables
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         conv_ie_reg <= 1'b0;
         cmp_ie_reg  <= 1'b0;
      end else if (wr) begin
         if (i_avs_address == IDX_IEN0) conv_ie_reg <= wd[B_CONV_IRQ];
         if (i_avs_address == IDX_IEN1) cmp_ie_reg  <= wd[B_CMP_IRQ];
      end
   end

   // pending flags: hardware set wins over a zero write
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         conv_pend_reg <= 1'b0;
         cmp_pend_reg  <= 1'b0;
      end else begin
         if (lk.conv_done) conv_pend_reg <= 1'b1;
         else if (wr && i_avs_address == IDX_IFL0 && !wd[B_CONV_IRQ])
            conv_pend_reg <= 1'b0;
         if (lk.cmp_event) cmp_pend_reg <= 1'b1;
         else if (wr && i_avs_address == IDX_IFL1 && !wd[B_CMP_IRQ])
            cmp_pend_reg <= 1'b0;
      end
   end

   // ==========================
   // converter control and result
   assign lk.conv_go  = wr && i_avs_address == IDX_CTL && wd[B_START] && !start_reg;
   assign lk.conv_div = div_reg;

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         start_reg <= 1'b0;
         div_reg   <= 3'h0;
      end else begin
         if (lk.conv_go)        start_reg <= 1'b1;
         else if (lk.conv_done) start_reg <= 1'b0;
         if (wr && i_avs_address == IDX_CTL) div_reg <= wd[2:0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst)           result_reg <= 12'h0;
      else if (lk.conv_done) result_reg <= i_conv_result;
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         ref_reg  <= RST_REF;
         chan_reg <= RST_CHAN;
      end else if (wr && i_avs_address == IDX_ISEL) begin
         ref_reg  <= wd[7:6];
         chan_reg <= wd[4:0];
      end
   end

   // ==========================
   // comparator configuration
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         cctl_reg <= RST_CCTL;
         csel_reg <= RST_CSEL;
         dac_reg  <= RST_DAC;
      end else if (wr) begin
         if (i_avs_address == IDX_CCTL) cctl_reg <= wd;
         if (i_avs_address == IDX_CSEL) csel_reg <= wd;
         if (i_avs_address == IDX_DAC)  dac_reg  <= wd;
      end
   end

   assign lk.cmp_pd   = cctl_reg[B_PD];
   assign lk.cmp_inv  = cctl_reg[B_INV];
   assign lk.cmp_trig = cctl_reg[3:2];
   assign lk.cmp_dbs  = cctl_reg[1:0];

   // ==========================
   // registered outputs to analog, pin and interrupt lines
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_conv_clk              <= 1'b0;
         o_conv_active           <= 1'b0;
         o_conv_channel_sel      <= RST_CHAN;
         o_conv_channel_valid    <= 1'b0; // reset channel code is reserved
         o_conv_reference_sel    <= RST_REF;
         o_comparator_power_down <= 1'b1;
         o_negative_source_sel   <= 1'b1;
         o_negative_pin_sel      <= 3'h7;
         o_negative_pin_connect  <= 1'b0;
         o_positive_pin_sel      <= 3'h7;
         o_positive_pin_connect  <= 1'b0;
         o_dac_reference_sel     <= 1'b0;
         o_dac_level_code        <= 7'h00;
         o_comparator_pin_out    <= 1'b0;
         o_comparator_pin_oe     <= 1'b0;
         o_conv_irq              <= 1'b0;
         o_comparator_irq        <= 1'b0;
      end else begin
         o_conv_clk           <= lk.conv_clk;
         o_conv_active        <= start_reg;
         o_conv_channel_sel   <= chan_reg;
         o_conv_channel_valid <= chan_reg <= CH_LAST_PIN || chan_reg == CH_BANDGAP
                                 || chan_reg == CH_QUARTER;
         o_conv_reference_sel <= ref_reg;
         o_comparator_power_down <= cctl_reg[B_PD];
         o_negative_source_sel   <= csel_reg[B_NEG_SRC];
         o_negative_pin_sel      <= csel_reg[6:4];
         o_negative_pin_connect  <= !csel_reg[6] && csel_reg[6:4] != NEG_RSVD;
         o_positive_pin_sel      <= csel_reg[2:0];
         o_positive_pin_connect  <= !csel_reg[2] && csel_reg[2:0] != POS_RSVD;
         o_dac_reference_sel     <= dac_reg[B_DAC_REF];
         o_dac_level_code        <= dac_reg[6:0];
         o_comparator_pin_out    <= lk.cmp_final;
         o_comparator_pin_oe     <= cctl_reg[B_OE];
         o_conv_irq              <= conv_pend_reg && conv_ie_reg;
         o_comparator_irq        <= cmp_pend_reg && cmp_ie_reg;
      end
   end

   // ==========================
   // submodules
   acc_conv_seq u_seq (
      .i_clk  (i_clk),
      .i_srst (i_srst),
      .lk     (lk.seq)
   );

   acc_cmp_filt u_filt (
      .i_clk  (i_clk),
      .i_srst (i_srst),
      .i_raw  (i_comparator_raw_out),
      .lk     (lk.filt)
   );

   // ==========================
   // checks
   property p_start;
      @(posedge i_clk) disable iff (i_srst)
      lk.conv_go |=> start_reg ##0 !lk.conv_done;
   endproperty
   a_start: assert property (p_start) else $error("start bit not set by write");

   property p_done;
      @(posedge i_clk) disable iff (i_srst)
      lk.conv_done |=> !start_reg && conv_pend_reg && result_reg == $past(i_conv_result);
   endproperty
   a_done: assert property (p_done) else $error("end of conversion update missing");

   property p_busy;
      @(posedge i_clk) disable iff (i_srst)
      $fell(start_reg) |-> $past(lk.conv_done);
   endproperty
   a_busy: assert property (p_busy) else $error("start bit cleared without end");

   property p_clr;
      @(posedge i_clk) disable iff (i_srst)
      (wr && i_avs_address == IDX_IFL0 && !wd[B_CONV_IRQ] && !lk.conv_done) |=> !conv_pend_reg;
   endproperty
   a_clr: assert property (p_clr) else $error("converter pending not cleared");

   property p_cmp_set;
      @(posedge i_clk) disable iff (i_srst)
      lk.cmp_event |=> cmp_pend_reg ##1 (o_comparator_irq == cmp_ie_reg || $past(wr));
   endproperty
   a_cmp_set: assert property (p_cmp_set) else $error("comparator pending not set");

   property p_rst;
      @(posedge i_clk)
      ($past(i_srst) && !i_srst) |-> chan_reg == RST_CHAN && ref_reg == RST_REF
                                    && cctl_reg[B_PD];
   endproperty
   a_rst: assert property (p_rst) else $error("reset values wrong");

   property p_pdraw;
      @(posedge i_clk) disable iff (i_srst)
      cctl_reg[B_PD] |-> lk.cmp_raw;
   endproperty
   a_pdraw: assert property (p_pdraw) else $error("raw output low while powered down");

   property p_oe;
      @(posedge i_clk) disable iff (i_srst)
      o_comparator_pin_oe |-> o_comparator_pin_out == $past(lk.cmp_final);
   endproperty
   a_oe: assert property (p_oe) else $error("pin does not follow final output");
endmodule
`default_nettype wire

// [verification/acc_analog_model.sv]
// Purpose: analog side model for converter and comparator
// Assumes: result is held from conversion start to one cycle after it
// Notes:   result lines show the inverse value while not driven
`timescale 1ns/1ps
`default_nettype none
module acc_analog_model (
   // clock
   input  wire logic        i_clk,
   // from block
   input  wire logic        i_active,
   input  wire logic        i_pd,
   // bench stimulus
   input  wire logic [11:0] i_value,
   input  wire logic        i_level,
   // to block
   output logic [11:0]      o_result,
   output logic             o_raw
);
   logic hold_reg;
   // ==========================
   // result drive window, one cycle past busy
   always_ff @(posedge i_clk) begin
      hold_reg <= i_active;
   end
   assign o_result = (i_active | hold_reg) ? i_value : ~i_value;
   // comparator output sits high while powered down
   assign o_raw = i_pd ? 1'b1 : i_level;
endmodule
`default_nettype wire

// [verification/tb.sv]
// Purpose: self-checking bench for converter and comparator control
// Assumes: analog model supplies result and comparator level
// Notes:   expectations come from the bench model, except the converter clock count taken from CONV_CLOCKS in acc_pkg
`timescale 1ns/1ps
`default_nettype none
module tb;
   import acc_pkg::*;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic [8:0]  adr = '0;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wd = '0;
   logic [31:0] rdat;
   logic        wreq, act, chv, pd, pin, oe, cirq, mirq, dref, raw, e;
   logic        nsrc, ncon, pcon, cclk, cclk_q;
   logic [2:0]  nsel, psel;
   logic [3:0]  be = 4'hf;
   int          ticks = 0;
   logic [4:0]  ch;
   logic [1:0]  rsel;
   logic [6:0]  lvl;
   logic [11:0] val = '0;
   logic [11:0] res;
   logic        level = 1'b0;
   logic [7:0]  q;
   logic [31:0] seed = 32'h12ac97cf;
   int          failures = 0;
   int          compares = 0;
   int          cycles = 0;
   int          busy = 0;
   int          x;
   // ==========================
   // design and analog model
   acc_top i_acc_top (
      .i_clk(clk), .i_srst(srst), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
      .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdat),
      .o_avs_waitrequest(wreq), .i_conv_result(res), .o_conv_clk(cclk), .o_conv_active(act),
      .o_conv_channel_sel(ch), .o_conv_channel_valid(chv), .o_conv_reference_sel(rsel),
      .i_comparator_raw_out(raw), .o_comparator_power_down(pd), .o_negative_source_sel(nsrc),
      .o_negative_pin_sel(nsel), .o_negative_pin_connect(ncon), .o_positive_pin_sel(psel),
      .o_positive_pin_connect(pcon), .o_dac_reference_sel(dref), .o_dac_level_code(lvl),
      .o_comparator_pin_out(pin), .o_comparator_pin_oe(oe), .o_conv_irq(cirq),
      .o_comparator_irq(mirq));
   acc_analog_model i_acc_analog_model (
      .i_clk(clk), .i_active(act), .i_pd(pd), .i_value(val), .i_level(level),
      .o_result(res), .o_raw(raw));
   // clock, busy counter and hang limit
   always #2 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (act === 1'b1) busy++;
      // rising edges of the converter clock
      cclk_q <= cclk;
      if (cclk === 1'b1 && cclk_q === 1'b0) ticks++;
      if (cycles == 20000) begin
         failures++;
         report_and_stop();
      end
   end
   // ==========================
   // helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [8:0] a, input logic [7:0] d);
      adr <= a;
      wd <= {24'h0, d};
      rd <= ~w;
      wr <= w;
      do begin
         @(posedge clk);
      end while (wreq !== 1'b0);
      q = rdat[7:0];
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rchk(input logic [8:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00);
      chk(q, exp);
   endtask
   task automatic report_and_stop();
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // ==========================
   // main sequence
   initial begin
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      // reset values and unmapped place
      rchk(IDX_IEN0, 8'h00);
      rchk(IDX_IFL0, 8'h00);
      rchk(IDX_CCTL, 8'hc0);
      rchk(IDX_ISEL, 8'h1f);
      rchk(IDX_CSEL, 8'hff);
      rchk(9'h100, 8'h00);
      chk({7'h0, pd}, 8'h01);
      // random channel, reference and level settings
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         bus(1'b1, IDX_ISEL, seed[7:0]);
         rchk(IDX_ISEL, seed[7:0] & 8'hdf);
         e = (seed[4:0] <= 5'h0c) || seed[4:0] == 5'h0e || seed[4:0] == 5'h17;
         chk({7'h0, chv}, {7'h0, e});
         chk({3'h0, ch}, {3'h0, seed[4:0]});
         chk({6'h0, rsel}, {6'h0, seed[7:6]});
         bus(1'b1, IDX_DAC, seed[15:8]);
         rchk(IDX_DAC, seed[15:8]);
         chk({dref, lvl}, seed[15:8]);
         bus(1'b1, IDX_CSEL, seed[23:16]);
         rchk(IDX_CSEL, seed[23:16]);
         chk({7'h0, nsrc}, {7'h0, seed[23]});
         e = !seed[22] && seed[22:20] != 3'h2;
         chk({nsel, ncon, 4'h0}, {seed[22:20], e, 4'h0});
         e = !seed[18] && seed[18:16] != 3'h3;
         chk({psel, pcon, 4'h0}, {seed[18:16], e, 4'h0});
      end
      // write without byte lane zero is ignored
      be <= 4'h0;
      bus(1'b1, IDX_DAC, ~seed[15:8]);
      be <= 4'hf;
      rchk(IDX_DAC, seed[15:8]);
      // supply reference, so no warm-up wait is needed
      bus(1'b1, IDX_ISEL, 8'h02);
      bus(1'b1, IDX_IEN0, 8'h80);
      // one conversion per divider code, second start refused
      // only code 000 keeps the converter clock legal at 250 MHz; others for timing
      for (int d = 0; d < 8; d++) begin
         seed = lfsr(seed);
         val <= seed[11:0];
         busy = 0;
         ticks = 0;
         bus(1'b1, IDX_CTL, {4'h0, 1'b1, d[2:0]});
         bus(1'b1, IDX_CTL, {4'h0, 1'b1, d[2:0]});
         do begin
            bus(1'b0, IDX_CTL, 8'h00);
         end while (q[3] !== 1'b0);
         x = 14 << (8 - d);
         chk({7'h0, busy >= x && busy <= x + 2}, 8'h01);
         chk(8'(ticks), {3'h0, CONV_CLOCKS});
         rchk(IDX_RESH, val[11:4]);
         rchk(IDX_CTL, {val[3:0], 1'b0, d[2:0]});
         chk({7'h0, cirq}, 8'h01);
         rchk(IDX_IFL0, 8'h80);
         bus(1'b1, IDX_IFL0, 8'h7f);
         rchk(IDX_IFL0, 8'h00);
         chk({7'h0, cirq}, 8'h00);
      end
      // each comparator trigger mode with the de-bounce length of the same code
      bus(1'b1, IDX_IEN1, 8'h10);
      for (int t = 0; t < 4; t++) begin
         level <= 1'b0;
         bus(1'b1, IDX_CCTL, {3'b001, 1'b0, t[1:0], t[1:0]});
         repeat (30) @(posedge clk);
         bus(1'b1, IDX_IFL1, 8'hef);
         rchk(IDX_IFL1, 8'h00);
         level <= 1'b1;
         repeat (30) @(posedge clk);
         chk({6'h0, oe, pin}, 8'h03);
         rchk(IDX_IFL1, {3'h0, t != 1, 4'h0});
         chk({7'h0, mirq}, {7'h0, t != 1});
         rchk(IDX_CCTL, {3'b011, 1'b0, t[1:0], t[1:0]});
         bus(1'b1, IDX_IFL1, 8'hef);
         level <= 1'b0;
         repeat (30) @(posedge clk);
         rchk(IDX_IFL1, {3'h0, t != 0, 4'h0});
      end
      // inversion, then a power-down edge still flags
      level <= 1'b1;
      bus(1'b1, IDX_CCTL, 8'h30);
      repeat (30) @(posedge clk);
      chk({7'h0, pin}, 8'h00);
      level <= 1'b0;
      bus(1'b1, IDX_CCTL, 8'h20);
      repeat (30) @(posedge clk);
      bus(1'b1, IDX_IFL1, 8'hef);
      rchk(IDX_IFL1, 8'h00);
      bus(1'b1, IDX_CCTL, 8'h80);
      repeat (30) @(posedge clk);
      rchk(IDX_IFL1, 8'h10);
      report_and_stop();
   end
endmodule
`default_nettype wire
